// *** design/ard_action_decoder.sv ***
`default_nettype none
// Function
// - control section: action word, two queue words, 32 slot, 128 channel, 64 descriptor words
// - each action request pulse seen while idle fetches the action word exactly once; pulses while busy are ignored
// - three-bit highway format field selects one of five frame formats
// - frames longer than the programmed maximum (up to 8191) raise frame_abort
// - no length check in transparent mode A or V.110/X.30
// - one maximum frame length shared by every logical channel
// - full init fetches all slot mapping plus the named channel setup
// - channel-only init loads only the named channel setup
// - mask bit of the last accepted action word suppresses the acknowledge or failure report
// - reinit-all loads full slot mapping and every channel setup
// - loop bits decode to none, complete or channelwise internal or external
// - complete external loop sends receive data straight to transmit output
// - complete internal loop feeds transmit back to receiver, ignores line
// - channelwise loop only flags the selected channel and direction on loop_channel, loop_cw_internal, loop_cw_external
// - attention bit rereads queue setup and redirects later entries
// - queue start address and length both come from the queue setup words
// - serviced request posts acknowledge, impossible one aborts and posts failure
module ard_action_decoder #(
  parameter int MFL_W = 13
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // action request pin and control section base
  input wire logic action_req_n,
  input wire logic [31:0] ctrl_base,
  // shared memory read port
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic mem_berr,
  // internal configuration store write port
  output logic cfg_we,
  output logic cfg_sel,
  output logic [6:0] cfg_idx,
  output logic [31:0] cfg_wdata,
  output logic slots_reinit,
  // decoded configuration
  output logic [31:0] action_request_word,
  output logic [31:0] interrupt_queue_base,
  output logic [12:0] iq_length_words,
  output logic [2:0] highway_format,
  output logic [MFL_W-1:0] max_frame_length,
  output logic [4:0] loop_channel,
  output logic loop_cw_internal,
  output logic loop_cw_external,
  output logic busy,
  // action result events
  output logic action_ack_flag,
  output logic action_fail_flag,
  // receive length check
  input wire logic rx_len_valid,
  input wire logic [2:0] rx_mode,
  input wire logic [MFL_W:0] rx_len,
  output logic frame_abort,
  // serial lines
  input wire logic ser_rx_pin,
  input wire logic tx_data,
  output logic ser_tx_out,
  output logic rx_data
);
  // ==========================================================
  // pin synchronisers
  logic req_s1, req_s2, req_s3, rx_s1, rx_s2;
  logic req_fall;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      req_s1 <= 1'b1;
      req_s2 <= 1'b1;
      req_s3 <= 1'b1;
      rx_s1 <= 1'b0;
      rx_s2 <= 1'b0;
    end else begin
      req_s1 <= action_req_n;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      rx_s1 <= ser_rx_pin;
      rx_s2 <= rx_s1;
    end
  end
  assign req_fall = req_s3 & ~req_s2;

  // ==========================================================
  // action word decode
  ard_pkg::ard_state_type state;
  logic [31:0] aw;
  logic [7:0] cnt;
  logic [2:0] loop_code;
  logic fmt_ok, loop_ok, init_ok, bad_word;
  assign aw = mem_rdata;
  assign loop_code = {aw[ard_pkg::B_CHANWISE], aw[ard_pkg::B_EXTERNAL], aw[ard_pkg::B_INTERNAL]};
  // only the five listed formats are legal
  assign fmt_ok = aw[ard_pkg::FMT_HI:ard_pkg::FMT_LO] inside
    {ard_pkg::FMT_T1_1536, ard_pkg::FMT_T1_1544, ard_pkg::FMT_CEPT, ard_pkg::FMT_4M_EVEN, ard_pkg::FMT_4M_ODD};
  // remaining loop combinations are refused
  assign loop_ok = loop_code inside
    {ard_pkg::LOOP_NONE, ard_pkg::LOOP_INT, ard_pkg::LOOP_EXT, ard_pkg::LOOP_OPEN,
     ard_pkg::LOOP_CW_INT, ard_pkg::LOOP_CW_EXT};
  assign init_ok = ($countones({aw[ard_pkg::B_FULL_INIT], aw[ard_pkg::B_CHAN_ONLY], aw[ard_pkg::B_REINIT]}) < 2);
  assign bad_word = ~(fmt_ok & loop_ok & init_ok);
  // ==========================================================
  // fetch sequencer
  logic word_done, last_tsa, last_chn, failed;
  logic [31:0] chn_base;
  assign word_done = mem_req & (mem_ack | mem_berr);
  assign last_tsa = (cnt == 8'(ard_pkg::TSA_WORDS - 1));
  assign last_chn = action_request_word[ard_pkg::B_REINIT] ?
    (cnt == 8'(ard_pkg::CHN_WORDS - 1)) : (cnt == 8'(ard_pkg::CHN_SPEC_WORDS - 1));
  assign chn_base = ard_pkg::OFF_CHN + 32'(action_request_word[ard_pkg::CHN_HI:ard_pkg::CHN_LO]) * ard_pkg::CHN_STRIDE;
  // next fetch after the action word or queue setup, in fixed order
  function automatic ard_pkg::ard_state_type after_iq(input logic [31:0] w);
    if (w[ard_pkg::B_FULL_INIT] | w[ard_pkg::B_REINIT])
      return ard_pkg::S_TSA;
    else if (w[ard_pkg::B_CHAN_ONLY])
      return ard_pkg::S_CHN;
    else
      return ard_pkg::S_DONE;
  endfunction
  // state, word counter and failure latch
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ard_pkg::S_IDLE;
      cnt <= 8'h00;
      failed <= 1'b0;
    end else begin
      unique case (state)
        ard_pkg::S_IDLE: begin
          failed <= 1'b0;
          cnt <= 8'h00;
          if (req_fall) begin
            state <= ard_pkg::S_ACT;
          end
        end
        ard_pkg::S_ACT: begin
          if (word_done) begin
            if (mem_berr | bad_word) begin
              failed <= 1'b1;
              state <= ard_pkg::S_DONE;
            end else if (aw[ard_pkg::B_ATTENTION]) begin
              state <= ard_pkg::S_IQA;
            end else begin
              state <= after_iq(aw);
            end
          end
        end
        ard_pkg::S_IQA: begin
          if (word_done) begin
            failed <= mem_berr;
            state <= mem_berr ? ard_pkg::S_DONE : ard_pkg::S_IQL;
          end
        end
        ard_pkg::S_IQL: begin
          if (word_done) begin
            failed <= mem_berr;
            state <= mem_berr ? ard_pkg::S_DONE : after_iq(action_request_word);
          end
        end
        ard_pkg::S_TSA: begin
          if (word_done) begin
            cnt <= (last_tsa | mem_berr) ? 8'h00 : cnt + 8'h01;
            failed <= mem_berr;
            if (mem_berr) begin
              state <= ard_pkg::S_DONE;
            end else if (last_tsa) begin
              state <= ard_pkg::S_CHN;
            end
          end
        end
        ard_pkg::S_CHN: begin
          if (word_done) begin
            cnt <= cnt + 8'h01;
            failed <= mem_berr;
            if (mem_berr | last_chn) begin
              state <= ard_pkg::S_DONE;
            end
          end
        end
        ard_pkg::S_DONE: begin
          state <= ard_pkg::S_IDLE;
        end
      endcase
    end
  end

  // memory request and address, held until the answer
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mem_req <= 1'b0;
      mem_addr <= 32'h0000_0000;
    end else if (mem_req & ~word_done) begin
      mem_req <= 1'b1;
    end else begin
      mem_req <= 1'b0;
      unique case (state)
        ard_pkg::S_IDLE: begin
          mem_req <= req_fall;
          mem_addr <= ctrl_base + ard_pkg::OFF_ACT;
        end
        ard_pkg::S_ACT, ard_pkg::S_IQA, ard_pkg::S_IQL, ard_pkg::S_DONE: begin
          mem_req <= ~mem_req & (state != ard_pkg::S_DONE);
        end
        ard_pkg::S_TSA: begin
          mem_req <= ~mem_req;
          mem_addr <= ctrl_base + ard_pkg::OFF_TSA + 32'(cnt) * ard_pkg::WORD_BYTES;
        end
        ard_pkg::S_CHN: begin
          mem_req <= ~mem_req;
          mem_addr <= ctrl_base + (action_request_word[ard_pkg::B_REINIT] ? ard_pkg::OFF_CHN : chn_base) +
            32'(cnt) * ard_pkg::WORD_BYTES;
        end
      endcase
      if (state == ard_pkg::S_ACT && word_done) begin
        mem_addr <= ctrl_base + ard_pkg::OFF_IQ;
      end else if (state == ard_pkg::S_IQA && word_done) begin
        mem_addr <= ctrl_base + ard_pkg::OFF_IQ + ard_pkg::WORD_BYTES;
      end
    end
  end

  // ==========================================================
  // stored words and decoded fields
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      action_request_word <= 32'h0000_0000;
      highway_format <= ard_pkg::FMT_T1_1536;
      max_frame_length <= MFL_W'(ard_pkg::MFL_RESET);
      loop_channel <= 5'h00;
    end else if (state == ard_pkg::S_ACT && mem_ack && !bad_word) begin
      action_request_word <= aw;
      highway_format <= aw[ard_pkg::FMT_HI:ard_pkg::FMT_LO];
      max_frame_length <= aw[ard_pkg::MFL_HI:ard_pkg::MFL_LO];
      loop_channel <= aw[ard_pkg::CHN_HI:ard_pkg::CHN_LO];
    end
  end
  // loop state: one code at a time, opened by the open code
  logic [2:0] loop_mode;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loop_mode <= ard_pkg::LOOP_NONE;
      loop_cw_internal <= 1'b0;
      loop_cw_external <= 1'b0;
    end else if (state == ard_pkg::S_ACT && mem_ack && !bad_word) begin
      loop_mode <= (loop_code == ard_pkg::LOOP_OPEN) ? ard_pkg::LOOP_NONE : loop_code;
      loop_cw_internal <= (loop_code == ard_pkg::LOOP_CW_INT);
      loop_cw_external <= (loop_code == ard_pkg::LOOP_CW_EXT);
    end
  end
  // interrupt queue setup
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      interrupt_queue_base <= 32'h0000_0000;
      iq_length_words <= 13'h0000;
    end else if (state == ard_pkg::S_IQA && mem_ack) begin
      interrupt_queue_base <= {mem_rdata[31:2], ard_pkg::ADDR_LSB_ZERO};
    end else if (state == ard_pkg::S_IQL && mem_ack) begin
      iq_length_words <= (13'(mem_rdata[ard_pkg::IQLEN_W-1:0]) + 13'h0001) << ard_pkg::IQLEN_SHIFT;
    end
  end
  // configuration store writes, index and data held after the last write
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_we <= 1'b0;
      cfg_sel <= ard_pkg::CFG_SEL_TSA;
      cfg_idx <= 7'h00;
      cfg_wdata <= 32'h0000_0000;
    end else begin
      cfg_we <= mem_ack & (state == ard_pkg::S_TSA || state == ard_pkg::S_CHN);
      if (mem_ack && (state == ard_pkg::S_TSA || state == ard_pkg::S_CHN)) begin
        cfg_sel <= (state == ard_pkg::S_CHN) ? ard_pkg::CFG_SEL_CHN : ard_pkg::CFG_SEL_TSA;
        cfg_idx <= (state == ard_pkg::S_CHN && !action_request_word[ard_pkg::B_REINIT]) ?
          7'({action_request_word[ard_pkg::CHN_HI:ard_pkg::CHN_LO], cnt[1:0]}) : cnt[6:0];
        cfg_wdata <= mem_rdata;
      end
    end
  end
  // completion events and busy
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      action_ack_flag <= 1'b0;
      action_fail_flag <= 1'b0;
      slots_reinit <= 1'b0;
      busy <= 1'b0;
    end else begin
      action_ack_flag <= (state == ard_pkg::S_DONE) & ~failed & ~action_request_word[ard_pkg::B_MASK];
      action_fail_flag <= (state == ard_pkg::S_DONE) & failed & ~action_request_word[ard_pkg::B_MASK];
      slots_reinit <= (state == ard_pkg::S_DONE) & ~failed & action_request_word[ard_pkg::B_REINIT];
      busy <= (state != ard_pkg::S_IDLE) | req_fall;
    end
  end

  // ==========================================================
  // length check and serial loops
  logic len_checked;
  assign len_checked = (rx_mode != ard_pkg::MODE_TMA) && (rx_mode != ard_pkg::MODE_V110);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      frame_abort <= 1'b0;
      ser_tx_out <= 1'b0;
      rx_data <= 1'b0;
    end else begin
      frame_abort <= rx_len_valid & len_checked & (rx_len > {1'b0, max_frame_length});
      ser_tx_out <= (loop_mode == ard_pkg::LOOP_EXT) ? rx_s2 : tx_data;
      rx_data <= (loop_mode == ard_pkg::LOOP_INT) ? tx_data : rx_s2;
    end
  end

  // ==========================================================
  // assertions
  sequence s_req_seen;
    req_fall && state == ard_pkg::S_IDLE;
  endsequence
  property p_fetch_action;
    @(posedge core_clk) disable iff (sys_rst)
      s_req_seen |=> mem_req && mem_addr == ctrl_base + ard_pkg::OFF_ACT;
  endproperty
  a_fetch_action: assert property (p_fetch_action) else $error("action word not fetched");
  property p_abort;
    @(posedge core_clk) disable iff (sys_rst)
      rx_len_valid && len_checked && rx_len > {1'b0, max_frame_length} |=> frame_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("overlong frame not aborted");
  property p_no_check;
    @(posedge core_clk) disable iff (sys_rst) !len_checked |=> !frame_abort;
  endproperty
  a_no_check: assert property (p_no_check) else $error("exempt mode aborted a frame");
  property p_mask;
    @(posedge core_clk) disable iff (sys_rst)
      action_request_word[ard_pkg::B_MASK] && state == ard_pkg::S_DONE |=> !action_ack_flag && !action_fail_flag;
  endproperty
  a_mask: assert property (p_mask) else $error("masked result reported");
  property p_bad_fmt;
    @(posedge core_clk) disable iff (sys_rst)
      state == ard_pkg::S_ACT && mem_ack && !fmt_ok && !action_request_word[ard_pkg::B_MASK]
      |=> ##1 action_fail_flag;
  endproperty
  a_bad_fmt: assert property (p_bad_fmt) else $error("illegal format not failed");
  property p_ext_loop;
    @(posedge core_clk) disable iff (sys_rst) loop_mode == ard_pkg::LOOP_EXT |=> ser_tx_out == $past(rx_s2);
  endproperty
  a_ext_loop: assert property (p_ext_loop) else $error("external loop broken");
  property p_int_loop;
    @(posedge core_clk) disable iff (sys_rst) loop_mode == ard_pkg::LOOP_INT |=> rx_data == $past(tx_data);
  endproperty
  a_int_loop: assert property (p_int_loop) else $error("internal loop broken");
  property p_iq_align;
    @(posedge core_clk) disable iff (sys_rst) interrupt_queue_base[1:0] == ard_pkg::ADDR_LSB_ZERO;
  endproperty
  a_iq_align: assert property (p_iq_align) else $error("queue base unaligned");
  property p_chan_only;
    @(posedge core_clk) disable iff (sys_rst)
      cfg_we && action_request_word[ard_pkg::B_CHAN_ONLY] |-> cfg_sel == ard_pkg::CFG_SEL_CHN;
  endproperty
  a_chan_only: assert property (p_chan_only) else $error("slot map written on channel-only");
endmodule
`default_nettype wire

// *** design/ard_pkg.sv ***
`default_nettype none
package ard_pkg;
  // ==========================================================
  // control section layout, long-word counts and byte offsets
  localparam int ACT_WORDS = 1;
  localparam int IQ_WORDS = 2;
  localparam int TSA_WORDS = 32;
  localparam int CHN_WORDS = 128;
  localparam int DESC_WORDS = 64;
  localparam int CHN_COUNT = 32;
  localparam int CHN_SPEC_WORDS = CHN_WORDS / CHN_COUNT;
  localparam logic [31:0] OFF_ACT = 32'h0000_0000;
  localparam logic [31:0] OFF_IQ = 32'h0000_0004;
  localparam logic [31:0] OFF_TSA = 32'h0000_000C;
  localparam logic [31:0] OFF_CHN = 32'h0000_008C;
  localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
  localparam logic [31:0] CHN_STRIDE = 32'h0000_0010;
  // ==========================================================
  // action word fields
  localparam int FMT_HI = 31;
  localparam int FMT_LO = 29;
  localparam int MFL_HI = 28;
  localparam int MFL_LO = 16;
  localparam int B_FULL_INIT = 15;
  localparam int B_CHAN_ONLY = 14;
  localparam int CHN_HI = 12;
  localparam int CHN_LO = 8;
  localparam int B_MASK = 7;
  localparam int B_REINIT = 6;
  localparam int B_CHANWISE = 5;
  localparam int B_EXTERNAL = 4;
  localparam int B_INTERNAL = 3;
  localparam int B_ATTENTION = 2;
  // ==========================================================
  // highway formats
  localparam logic [2:0] FMT_T1_1536 = 3'h0;
  localparam logic [2:0] FMT_T1_1544 = 3'h4;
  localparam logic [2:0] FMT_CEPT = 3'h5;
  localparam logic [2:0] FMT_4M_EVEN = 3'h6;
  localparam logic [2:0] FMT_4M_ODD = 3'h7;
  // ==========================================================
  // loop codes as {channelwise, external, internal}
  localparam logic [2:0] LOOP_NONE = 3'h0;
  localparam logic [2:0] LOOP_INT = 3'h1;
  localparam logic [2:0] LOOP_EXT = 3'h2;
  localparam logic [2:0] LOOP_OPEN = 3'h3;
  localparam logic [2:0] LOOP_CW_INT = 3'h5;
  localparam logic [2:0] LOOP_CW_EXT = 3'h6;
  // ==========================================================
  // channel modes seen by the length check
  localparam logic [2:0] MODE_TMA = 3'h0;
  localparam logic [2:0] MODE_V110 = 3'h1;
  // ==========================================================
  // queue length field and scaling, reset values
  localparam int IQLEN_W = 8;
  localparam int IQLEN_SHIFT = 4;
  localparam logic [12:0] MFL_RESET = 13'h0000;
  localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;
  localparam logic CFG_SEL_TSA = 1'b0;
  localparam logic CFG_SEL_CHN = 1'b1;
  typedef enum logic [2:0] {S_IDLE, S_ACT, S_IQA, S_IQL, S_TSA, S_CHN, S_DONE} ard_state_type;
endpackage
`default_nettype wire

// *** verif/action_request_decoder_bench.sv ***
`default_nettype none
module action_request_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // signals
  logic core_clk, sys_rst, action_req_n, mem_req, mem_ack, mem_berr;
  logic [31:0] ctrl_base, mem_addr, mem_rdata, cfg_wdata, action_request_word, interrupt_queue_base;
  logic cfg_we, cfg_sel, slots_reinit, loop_cw_internal, loop_cw_external, busy;
  logic action_ack_flag, action_fail_flag, rx_len_valid, frame_abort, ser_rx_pin, tx_data, ser_tx_out, rx_data;
  logic [6:0] cfg_idx;
  logic [12:0] iq_length_words, max_frame_length;
  logic [2:0] highway_format, rx_mode;
  logic [4:0] loop_channel;
  logic [13:0] rx_len;
  int num_errors = 0;
  int n_checks = 0;
  int n_ack = 0, n_fail = 0, n_we = 0, n_abt = 0, n_rei = 0;
  ard_action_decoder #(.MFL_W(13)) dut (.core_clk, .sys_rst, .action_req_n, .ctrl_base, .mem_req, .mem_addr,
    .mem_rdata, .mem_ack, .mem_berr, .cfg_we, .cfg_sel, .cfg_idx, .cfg_wdata, .slots_reinit,
    .action_request_word, .interrupt_queue_base, .iq_length_words, .highway_format, .max_frame_length,
    .loop_channel, .loop_cw_internal, .loop_cw_external, .busy, .action_ack_flag, .action_fail_flag,
    .rx_len_valid, .rx_mode, .rx_len, .frame_abort, .ser_rx_pin, .tx_data, .ser_tx_out, .rx_data);
  ard_mem_host mdl (.core_clk, .mem_req, .mem_addr, .ctrl_base, .mem_rdata, .mem_ack, .mem_berr);
  // ==========================================================
  // event counters, sampled before the edge updates land
  always @(posedge core_clk) begin
    n_ack += int'(action_ack_flag === 1'b1);
    n_fail += int'(action_fail_flag === 1'b1);
    n_we += int'(cfg_we === 1'b1);
    n_abt += int'(frame_abort === 1'b1);
    n_rei += int'(slots_reinit === 1'b1);
  end
  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] aw(input logic [2:0] f, input logic [12:0] m, input logic [15:0] lo);
    return {f, m, lo};
  endfunction
  // one request, waits for the result before returning
  task automatic req(input logic [31:0] w, input int ea, input int ef, input int ewe);
    int a0, f0, w0, k;
    a0 = n_ack;
    f0 = n_fail;
    w0 = n_we;
    mdl.mem[0] = w;
    @(posedge core_clk);
    action_req_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    action_req_n <= 1'b1;
    for (k = 0; k < 20 && busy !== 1'b1; k++) @(posedge core_clk);
    for (k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(n_ack - a0), 32'(ea));
    chk(32'(n_fail - f0), 32'(ef));
    chk(32'(n_we - w0), 32'(ewe));
  endtask
  task automatic rxc(input logic [2:0] m, input logic [13:0] l, input int e);
    int b0;
    b0 = n_abt;
    @(posedge core_clk);
    rx_len_valid <= 1'b1;
    rx_mode <= m;
    rx_len <= l;
    @(posedge core_clk);
    rx_len_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(n_abt - b0), 32'(e));
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(32'(highway_format), 32'h0);
    chk(32'(max_frame_length), 32'h0);
    chk({busy, loop_cw_internal, loop_cw_external}, 32'h0);
  endtask
  task automatic t_formats;
    logic [2:0] fl [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 5; i++) begin
      mdl.lat = i;
      req(aw(fl[i], 13'h1FFF - 13'(i), 16'h0000), 1, 0, 0);
      chk(32'(highway_format), 32'(fl[i]));
      chk(32'(max_frame_length), 32'(13'h1FFF - 13'(i)));
      chk(action_request_word, aw(fl[i], 13'h1FFF - 13'(i), 16'h0000));
    end
    mdl.lat = 0;
  endtask
  // refused words leave the configuration as it was
  task automatic t_illegal;
    req(aw(3'h1, 13'h0064, 16'h0000), 0, 1, 0);
    req(aw(3'h5, 13'h0064, 16'hC000), 0, 1, 0);
    req(aw(3'h5, 13'h0064, 16'h0020), 0, 1, 0);
    req(aw(3'h5, 13'h0064, 16'h0038), 0, 1, 0);
    chk(32'(highway_format), 32'h7);
    chk(32'(max_frame_length), 32'h1FFB);
  endtask
  task automatic t_length;
    req(aw(3'h5, 13'h0064, 16'h0000), 1, 0, 0);
    rxc(3'h2, 14'h0065, 1);
    rxc(3'h2, 14'h0064, 0);
    rxc(3'h0, 14'h1FFF, 0);
    rxc(3'h1, 14'h1FFF, 0);
    rxc(3'h4, 14'h0065, 1);
  endtask
  task automatic t_attn;
    mdl.mem[1] = 32'h0002_0013;
    mdl.mem[2] = 32'h0000_0003;
    mdl.lat = 2;
    req(aw(3'h5, 13'h0064, 16'h0004), 1, 0, 0);
    chk(interrupt_queue_base, 32'h0002_0010);
    chk(32'(iq_length_words), 32'h0000_0040);
    mdl.lat = 0;
  endtask
  // slots taken as switched off by the host before full init
  task automatic t_init;
    int r0;
    r0 = n_rei;
    req(aw(3'h5, 13'h0064, 16'h4500), 1, 0, 4);
    chk({cfg_sel, cfg_idx}, 32'h97);
    chk(cfg_wdata, 32'hA500_003A);
    req(aw(3'h5, 13'h0064, 16'h8300), 1, 0, 36);
    chk(cfg_wdata, 32'hA500_0032);
    req(aw(3'h5, 13'h0064, 16'h0040), 1, 0, 160);
    chk(32'(cfg_idx), 32'h7F);
    chk(32'(n_rei - r0), 32'h1);
  endtask
  task automatic t_mask_berr;
    req(aw(3'h5, 13'h0064, 16'h4580), 0, 0, 4);
    mdl.bad_addr = 32'h0000_10E0;
    req(aw(3'h5, 13'h0064, 16'h4500), 0, 1, 1);
    mdl.bad_addr = 32'hFFFF_FFFF;
  endtask
  task automatic lp(input logic [15:0] lo, input logic [2:0] e);
    req(aw(3'h5, 13'h0064, lo), 1, 0, 0);
    chk({loop_channel, loop_cw_internal, loop_cw_external}, 32'({lo[12:8], e[1:0]}));
  endtask
  // complete loops pass data through; channelwise codes set loop channel and direction flags
  task automatic t_loops;
    lp(16'h0510, 3'h0);
    for (int v = 0; v < 2; v++) begin
      ser_rx_pin <= v[0];
      repeat (6) @(posedge core_clk);
      #1;
      chk(32'(ser_tx_out), 32'(v));
    end
    lp(16'h0508, 3'h0);
    for (int v = 0; v < 2; v++) begin
      tx_data <= v[0];
      ser_rx_pin <= ~v[0];
      repeat (4) @(posedge core_clk);
      #1;
      chk(32'(rx_data), 32'(v));
    end
    lp(16'h0728, 3'h2);
    lp(16'h0718, 3'h0);
    lp(16'h0730, 3'h1);
  endtask
  task automatic tally_and_finish;
    if (num_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // clock, watchdog and main sequence
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    sys_rst = 1'b1;
    action_req_n = 1'b1;
    ctrl_base = 32'h0000_1000;
    rx_len_valid = 1'b0;
    rx_mode = 3'h0;
    rx_len = 14'h0000;
    ser_rx_pin = 1'b0;
    tx_data = 1'b0;
    for (int i = 0; i < 256; i++) mdl.mem[i] = 32'hA500_0000 | 32'(i);
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    t_reset;
    t_formats;
    t_illegal;
    t_length;
    t_attn;
    t_init;
    t_mask_berr;
    t_loops;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// *** verif/ard_mem_host.sv ***
`default_nettype none
module ard_mem_host (
  // clock
  input wire logic core_clk,
  // read port seen from the shared memory side
  input wire logic mem_req,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] ctrl_base,
  output logic [31:0] mem_rdata,
  output logic mem_ack,
  output logic mem_berr
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // control section image: word 0 action, 1-2 queue, 3.. slot map, 35.. channels
  logic [31:0] mem [0:255];
  int lat = 0;
  logic [31:0] bad_addr = 32'hFFFF_FFFF;
  int cnt = 0;
  logic [7:0] idx;
  assign idx = 8'((mem_addr - ctrl_base) >> 2);
  initial begin
    mem_ack = 1'b0;
    mem_berr = 1'b0;
    mem_rdata = 32'h5A5A_5A5A;
  end
  // answer each read once after lat waits; data toggles while not answering
  always @(posedge core_clk) begin
    mem_ack <= 1'b0;
    mem_berr <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack && !mem_berr) begin
      if (cnt >= lat) begin
        cnt <= 0;
        mem_ack <= (mem_addr != bad_addr);
        mem_berr <= (mem_addr == bad_addr);
        mem_rdata <= mem[idx];
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire
